// ===== shared/palette_cfg.svh
// palette access block: register offsets, field positions, reset values
// assumes inclusion by bare name from package and design files
`ifndef PALETTE_CFG_SVH
`define PALETTE_CFG_SVH
// ==========================================================
// direct register select codes
`define REG_PAL_WADDR 4'h0
`define REG_PAL_DATA 4'h1
`define REG_READ_MASK 4'h2
`define REG_PAL_RADDR 4'h3
`define REG_COL_WADDR 4'h4
`define REG_COL_DATA 4'h5
`define REG_COL_RADDR 4'h7
`define REG_INDEXED 4'hA
// ==========================================================
// extended register indices
`define IDX_PALETTE_PAGE 8'h1C
`define IDX_MISC_CTRL 8'h1E
`define IDX_TEST_DATA 8'h3B
`define IDX_ID 8'h3F
// ==========================================================
// field positions and reset values
`define MISC_WIDTH_OVERRIDE 2
`define MISC_WIDTH_VALUE 3
`define RESET_READ_MASK 8'hFF
`define RESET_PAGE 8'h00
`define RESET_MISC 8'h00
`define RESET_MUX_MODE 2'h0
// arbitrary identification value
`define DEVICE_ID 8'h5A
`endif

// ===== shared/palette_pkg.sv
// palette access block: shared types
// assumes palette_cfg.svh is on the include path
package palette_pkg;
  `include "palette_cfg.svh"

  typedef enum logic [1:0] {
    PHASE_RED,
    PHASE_GREEN,
    PHASE_BLUE
  } phase_type;

  // number of pixel bits that address the palette
  typedef enum logic [1:0] {
    PLANES_8,
    PLANES_4,
    PLANES_2,
    PLANES_1
  } planes_type;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rgb_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] sel;
    logic [7:0] data;
  } bus_req_type;
endpackage

// ===== verilog/palette_ram.sv
// palette_ram: 256 x 24 dual-ported color table
// assumes one clock for both ports; host port writes whole bytes by lane
`timescale 1ns/1ns
module palette_ram
  import palette_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic [AW-1:0] hostAddr,
  input wire logic [2:0] hostWe,
  input wire logic [7:0] hostWdata,
  output rgb_type hostRdata,
  input wire logic [AW-1:0] pixAddr,
  output rgb_type pixRdata
);
  rgb_type mem [DEPTH];

  // ==========================================================
  // host port: byte lane writes, read beside them
  always_ff @(posedge clk) begin
    if (ce) begin
      if (hostWe[2]) begin
        mem[hostAddr].red <= hostWdata; // RL13
      end
      if (hostWe[1]) begin
        mem[hostAddr].green <= hostWdata;
      end
      if (hostWe[0]) begin
        mem[hostAddr].blue <= hostWdata;
      end
      hostRdata <= mem[hostAddr];
    end
  end

  // ==========================================================
  // pixel port: independent of host traffic
  always_ff @(posedge clk) begin
    if (ce) begin
      pixRdata <= mem[pixAddr]; // RL20
    end
  end
endmodule // palette_ram

// ===== verilog/palette_color_access.sv
// palette_color_access: host register access and pixel lookup of the palette
// assumes the host strobes are asynchronous pins; pixel inputs are on clk
//
// Contract
// RL1: width select pin high gives 8-bit path, low gives 6-bit path.
// RL2: override bit set makes the width-value bit choose 8 or 6.
// RL3: override bit clears at reset so the pin governs width.
// RL4: pseudo-color and VGA pixel address bits are ANDed with read mask.
// RL5: with 1, 2 or 4 planes, upper address bits come from page register.
// RL6: page bits are merged after the mask, mask never touches them.
// RL7: narrow direct-color overlay fields get upper planes from page register.
// RL8: host loads color write address; low two bits choose the color.
// RL9: three color data writes load red, green, blue then advance.
// RL10: three color data reads return red, green, blue then advance.
// RL11: color address cycles overscan, cursor 0, 1, 2 and repeats.
// RL12: palette address auto-increments after each full transfer, wrapping to zero.
// RL13: each palette word holds 24 bits; full bytes kept in 6-bit mode.
// RL14: 6-bit mode palette reads return top two bits as zero.
// RL15: 6-bit output mux shifts low six bits up, zero fills bottom.
// RL16: test data and CRC sample after the output mux.
// RL17: host accesses complete within one dot clock; here read data reaches dataOut on the third clk edge after rd_b falls.
// RL18: host writes start address then red, green, blue bytes.
// RL19: host writes read address then reads red, green, blue.
// RL20: palette RAM is dual-ported; host reads never disturb pixel lookup.
// RL21: select code zero is both palette write address and index pointer.
// RL22: writing any address register resets the byte phase to red.
`timescale 1ns/1ns
`include "palette_cfg.svh"
module palette_color_access
  import palette_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic [3:0] regSel,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  input wire logic widthSelect,
  input wire logic [7:0] pixelIn,
  input wire logic directColor,
  input wire planes_type pixelPlanes,
  output rgb_type dacColor,
  output logic [7:0] crcRemainder
);
  // ==========================================================
  // pin synchronisers
  // select and data pins ride the same two stages as the strobes, so they line up
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  logic [3:0] selMeta;
  logic [3:0] selSync;
  logic [7:0] dinMeta;
  logic [7:0] dinSync;
  logic rdPrev;
  logic wrPrev;
  logic rdStart;
  logic wrDone;
  bus_req_type req;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta <= 6'h03;
      pinSync <= 6'h03;
      selMeta <= 4'h0;
      selSync <= 4'h0;
      dinMeta <= 8'h00;
      dinSync <= 8'h00;
    end else if (ce) begin
      pinMeta <= {4'h0, rd_b, wr_b};
      pinSync <= pinMeta;
      selMeta <= regSel;
      selSync <= selMeta;
      dinMeta <= dataIn;
      dinSync <= dinMeta;
    end
  end

  // width pin gets its own pair so it never mixes into strobe logic
  logic widthMeta;
  logic widthSync;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      widthMeta <= 1'b0;
      widthSync <= 1'b0;
    end else if (ce) begin
      widthMeta <= widthSelect;
      widthSync <= widthMeta;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPrev <= 1'b1;
      wrPrev <= 1'b1;
    end else if (ce) begin
      rdPrev <= pinSync[1];
      wrPrev <= pinSync[0];
    end
  end

  // reads act on the falling edge so data is ready while rd_b is low;
  // writes act on the rising edge when the host data is settled
  assign rdStart = rdPrev & ~pinSync[1];
  assign wrDone = ~wrPrev & pinSync[0];
  assign req = '{rd: rdStart, wr: wrDone, sel: selSync, data: dinSync};

  // ==========================================================
  // control registers
  logic [7:0] indexAddr;
  logic [7:0] palReadAddr;
  logic [7:0] readMask;
  logic [7:0] pageReg;
  logic [7:0] miscCtrl;
  logic [1:0] colorAddr;
  phase_type palPhase;
  phase_type colPhase;
  rgb_type colorRegs [4];
  logic palReadMode;
  logic eightBit;

  function automatic logic isSel(input bus_req_type r, input logic [3:0] code);
    return r.sel == code;
  endfunction

  function automatic phase_type nextPhase(input phase_type p);
    return (p == PHASE_BLUE) ? PHASE_RED : phase_type'(p + 2'd1);
  endfunction

  assign eightBit = miscCtrl[`MISC_WIDTH_OVERRIDE] ? miscCtrl[`MISC_WIDTH_VALUE] // RL2
                                                   : widthSync; // RL1

  // indexed writes land in whichever register the shared pointer names
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readMask <= `RESET_READ_MASK;
      pageReg <= `RESET_PAGE;
      miscCtrl <= `RESET_MISC; // RL3
    end else if (ce && req.wr) begin
      if (isSel(req, `REG_READ_MASK)) begin
        readMask <= req.data;
      end
      if (isSel(req, `REG_INDEXED) && indexAddr == `IDX_PALETTE_PAGE) begin
        pageReg <= req.data;
      end
      if (isSel(req, `REG_INDEXED) && indexAddr == `IDX_MISC_CTRL) begin
        miscCtrl <= req.data;
      end
    end
  end

  // ==========================================================
  // palette address and byte phase
  logic palXfer;
  logic [2:0] ramWe;
  assign palXfer = isSel(req, `REG_PAL_DATA) && (req.wr || req.rd);
  assign ramWe = (req.wr && isSel(req, `REG_PAL_DATA)) ?
                 ((palPhase == PHASE_RED) ? 3'h4 : (palPhase == PHASE_GREEN) ? 3'h2 : 3'h1)
                 : 3'h0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      indexAddr <= 8'h00;
      palReadAddr <= 8'h00;
      palPhase <= PHASE_RED;
      palReadMode <= 1'b0;
    end else if (ce) begin
      if (req.wr && isSel(req, `REG_PAL_WADDR)) begin
        indexAddr <= req.data; // RL21
        palPhase <= PHASE_RED; // RL22
        palReadMode <= 1'b0;
      end else if (req.wr && isSel(req, `REG_PAL_RADDR)) begin
        palReadAddr <= req.data; // RL19
        palPhase <= PHASE_RED; // RL22
        palReadMode <= 1'b1;
      end else if (palXfer) begin
        palPhase <= nextPhase(palPhase);
        if (palPhase == PHASE_BLUE) begin
          // 8-bit add wraps from the last location to zero; the pointer that
          // addresses the RAM is the one that advances, whatever the direction
          if (palReadMode) begin
            palReadAddr <= palReadAddr + 8'h01; // RL12 RL19
          end else begin
            indexAddr <= indexAddr + 8'h01; // RL12
          end
        end
      end
    end
  end

  // ==========================================================
  // overscan and cursor colors
  // one pointer serves both color address registers, so a read start also moves writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      colorAddr <= 2'h0;
      colPhase <= PHASE_RED;
    end else if (ce) begin
      if (req.wr && (isSel(req, `REG_COL_WADDR) || isSel(req, `REG_COL_RADDR))) begin
        colorAddr <= req.data[1:0];
        colPhase <= PHASE_RED; // RL22
      end else if (isSel(req, `REG_COL_DATA) && (req.wr || req.rd)) begin
        colPhase <= nextPhase(colPhase);
        if (colPhase == PHASE_BLUE) begin
          colorAddr <= colorAddr + 2'h1; // RL11
        end
      end
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_color
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        colorRegs[c] <= '0;
      end else if (ce && req.wr && isSel(req, `REG_COL_DATA) && colorAddr == 2'(c)) begin
        case (colPhase)
          PHASE_RED: colorRegs[c].red <= req.data; // RL9
          PHASE_GREEN: colorRegs[c].green <= req.data;
          PHASE_BLUE: colorRegs[c].blue <= req.data;
          default: colorRegs[c].red <= colorRegs[c].red;
        endcase
      end
    end
  end

  // ==========================================================
  // pixel address: mask, then page insertion
  logic [7:0] maskedPixel;
  logic [7:0] pixAddr;
  logic [7:0] hostRamAddr;
  rgb_type hostWord;
  rgb_type pixWord;
  rgb_type muxColor;

  // page bits are spliced in below, after the mask, so a cleared mask bit never hides a page
  // direct-color overlay keeps the raw field; only pseudo-color and VGA are masked
  assign maskedPixel = directColor ? pixelIn : (pixelIn & readMask); // RL4

  always_comb begin
    case (pixelPlanes)
      PLANES_4: pixAddr = {pageReg[7:4], maskedPixel[3:0]}; // RL5 RL6 RL7
      PLANES_2: pixAddr = {pageReg[7:2], maskedPixel[1:0]}; // RL5 RL6 RL7
      PLANES_1: pixAddr = {pageReg[7:1], maskedPixel[0]}; // RL5 RL6 RL7
      default: pixAddr = maskedPixel;
    endcase
  end

  assign hostRamAddr = palReadMode ? palReadAddr : indexAddr;

  palette_ram #(.DEPTH(DEPTH), .AW(8)) u_ram (
    .clk(clk),
    .ce(ce),
    .hostAddr(hostRamAddr),
    .hostWe(ramWe),
    .hostWdata(req.data),
    .hostRdata(hostWord),
    .pixAddr(pixAddr),
    .pixRdata(pixWord)
  );

  function automatic logic [7:0] toDac(input logic [7:0] v, input logic wide);
    return wide ? v : {v[5:0], 2'b00};
  endfunction

  always_comb begin
    muxColor.red = toDac(pixWord.red, eightBit); // RL15
    muxColor.green = toDac(pixWord.green, eightBit);
    muxColor.blue = toDac(pixWord.blue, eightBit);
  end

  // ==========================================================
  // output mux, test data and crc taps
  // both taps follow the mux, so 6-bit shifting is covered by the checksum too
  logic [7:0] testData;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dacColor <= '0;
      testData <= 8'h00;
      crcRemainder <= 8'h00;
    end else if (ce) begin
      dacColor <= muxColor;
      testData <= muxColor.red; // RL16
      crcRemainder <= {crcRemainder[6:0], 1'b0} ^ muxColor.red ^ muxColor.green
                      ^ muxColor.blue ^ (crcRemainder[7] ? 8'h07 : 8'h00); // RL16
    end
  end

  // ==========================================================
  // host read data
  function automatic logic [7:0] pickByte(input rgb_type w, input phase_type p);
    case (p)
      PHASE_RED: return w.red;
      PHASE_GREEN: return w.green;
      default: return w.blue;
    endcase
  endfunction

  // the 6-bit read view clears the top bits here only; the RAM keeps all eight
  logic [7:0] palByte;
  logic [7:0] next_dataOut;
  assign palByte = pickByte(hostWord, palPhase);
  always_comb begin
    case (req.sel)
      `REG_PAL_WADDR: next_dataOut = indexAddr;
      `REG_PAL_DATA: next_dataOut = eightBit ? palByte : {2'b00, palByte[5:0]}; // RL14
      `REG_READ_MASK: next_dataOut = readMask;
      `REG_PAL_RADDR: next_dataOut = palReadAddr;
      `REG_COL_WADDR: next_dataOut = {6'h00, colorAddr};
      `REG_COL_DATA: next_dataOut = pickByte(colorRegs[colorAddr], colPhase); // RL10
      `REG_COL_RADDR: next_dataOut = {6'h00, colorAddr};
      `REG_INDEXED: begin
        case (indexAddr)
          `IDX_PALETTE_PAGE: next_dataOut = pageReg;
          `IDX_MISC_CTRL: next_dataOut = miscCtrl;
          `IDX_TEST_DATA: next_dataOut = testData;
          `IDX_ID: next_dataOut = `DEVICE_ID;
          default: next_dataOut = 8'h00;
        endcase
      end
      default: next_dataOut = 8'h00;
    endcase
  end

  // data is captured at the read start and held for the whole strobe,
  // landing on the third clk edge after the host's falling edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dataOut <= 8'h00;
      dataOe <= 1'b0;
    end else if (ce) begin
      if (req.rd) begin
        dataOut <= next_dataOut; // RL17
      end
      dataOe <= ~pinSync[1];
    end
  end
endmodule // palette_color_access

// ===== bench/palette_color_access_checker.sv
// checker for palette_color_access: pin-level timing and output relations
// assumes clk is the only clock and rst_b the asynchronous reset
`timescale 1ns/1ns
module palette_color_access_checker
  import palette_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic [3:0] regSel,
  input wire logic [7:0] dataIn,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic widthSelect,
  input wire logic [7:0] pixelIn,
  input wire logic directColor,
  input wire planes_type pixelPlanes,
  input wire rgb_type dacColor,
  input wire logic [7:0] crcRemainder
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // host bus
  a_oe_rise: assert property ($fell(rd_b) |-> ##[2:4] dataOe)
    else $error("data enable late after read strobe");
  a_oe_drop: assert property (rd_b[*5] |-> !dataOe)
    else $error("data enable stuck without read");
  a_oe_cause: assert property ($rose(dataOe) |-> !rd_b)
    else $error("data enable without read strobe");
  a_dout_hold: assert property (rd_b[*5] |=> $stable(dataOut))
    else $error("read data changed between reads");
  // checked one edge into reset, once the asynchronous clear has surely landed
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_b |=> dataOut == 8'h00 && !dataOe && dacColor == 24'h000000)
    else $error("outputs not cleared in reset");
  // ==========================================================
  // pixel path
  a_six_low_zero: assert property ((!widthSelect)[*8] |-> dacColor.red[1:0] == 2'h0 &&
    dacColor.green[1:0] == 2'h0 && dacColor.blue[1:0] == 2'h0)
    else $error("6-bit output low bits not zero");
  a_freeze_dac: assert property (!ce |=> $stable(dacColor))
    else $error("color output moved while frozen");
  a_freeze_crc: assert property (!ce |=> $stable(crcRemainder))
    else $error("checksum moved while frozen");
  c_read: cover property ($fell(rd_b) ##[1:6] dataOe);
  c_freeze: cover property (!ce [*2]);
  c_six: cover property ((!widthSelect)[*8]);
endmodule // palette_color_access_checker

bind palette_color_access palette_color_access_checker #(.DEPTH(DEPTH))
  palette_color_access_checker_i (.clk, .rst_b, .ce, .rd_b, .wr_b, .regSel, .dataIn,
  .dataOut, .dataOe, .widthSelect, .pixelIn, .directColor, .pixelPlanes, .dacColor,
  .crcRemainder);

// ===== bench/palette_host.sv
// palette_host: host processor model on the register pins
// assumes the design syncs strobes with two flops on clk
`timescale 1ns/1ns
module palette_host (
  input wire logic clk,
  input wire logic [7:0] dataOut,
  output logic rd_b,
  output logic wr_b,
  output logic [3:0] regSel,
  output logic [7:0] dataIn
);
  initial begin
    rd_b = 1'b1;
    wr_b = 1'b1;
    regSel = 4'hF;
    dataIn = 8'h00;
  end
  // ==========================================================
  // bus cycles: six cycles low, six high, select held throughout
  task automatic put(input logic [3:0] s, input logic [7:0] d);
    @(posedge clk);
    regSel <= s;
    dataIn <= d;
    wr_b <= 1'b0;
    repeat (6) @(posedge clk);
    wr_b <= 1'b1;
    repeat (6) @(posedge clk);
    // released data lines must not keep the old value
    dataIn <= ~d;
  endtask
  task automatic get(input logic [3:0] s, output logic [7:0] d);
    @(posedge clk);
    regSel <= s;
    rd_b <= 1'b0;
    repeat (6) @(posedge clk);
    d = dataOut;
    rd_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule // palette_host

// ===== bench/palette_color_access_bench.sv
// palette_color_access_bench: model-based bench for host and pixel paths
// assumes palette_host drives the pins and the checker is bound in
`timescale 1ns/1ns
`include "palette_cfg.svh"
module palette_color_access_bench
  import palette_pkg::*;
;
  logic clk = 1'b0, rst_b, ce, rd_b, wr_b, dataOe, widthSelect, directColor;
  logic [3:0] regSel;
  logic [7:0] dataIn, dataOut, pixelIn, crcRemainder, v, mask, page, px, c;
  planes_type pixelPlanes;
  rgb_type dacColor, want;
  int n_errors = 0, check_count = 0, seed = 32'h527a, wide = 1;
  int pal[256][3], col[4][3], a, m;
  always #5 clk = ~clk;
  palette_color_access palette_color_access_i (.clk, .rst_b, .ce, .rd_b, .wr_b, .regSel,
    .dataIn, .dataOut, .dataOe, .widthSelect, .pixelIn, .directColor, .pixelPlanes,
    .dacColor, .crcRemainder);
  palette_host palette_host_i (.clk, .dataOut, .rd_b, .wr_b, .regSel, .dataIn);
  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] e);
    check_count++;
    if (seen !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    palette_host_i.put(s, d);
  endtask
  function automatic logic [7:0] sh(input int x);
    return wide ? 8'(x) : {x[5:0], 2'h0};
  endfunction
  task automatic readpal(input int st, input int n);
    wr(`REG_PAL_RADDR, 8'(st));
    for (int i = 0; i < n * 3; i++) begin
      palette_host_i.get(`REG_PAL_DATA, v);
      a = (st + i / 3) % 256;
      check("palette", v, wide ? pal[a][i % 3] : pal[a][i % 3] & 8'h3F);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    complete_run;
  end
  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    widthSelect = 1'b1;
    pixelIn = 8'h00;
    directColor = 1'b0;
    pixelPlanes = PLANES_8;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    palette_host_i.get(`REG_READ_MASK, v);
    check("mask reset", v, `RESET_READ_MASK);
    wr(`REG_PAL_WADDR, `IDX_MISC_CTRL);
    palette_host_i.get(`REG_INDEXED, v);
    check("misc reset", v, 8'h00);
    wr(`REG_PAL_WADDR, `IDX_ID);
    palette_host_i.get(`REG_INDEXED, v);
    check("id", v, `DEVICE_ID);
    $display("test reset done");
    wr(`REG_PAL_WADDR, 8'h00);
    wr(`REG_PAL_DATA, 8'h11);
    wr(`REG_PAL_WADDR, 8'h00);
    for (int i = 0; i < 771; i++) begin
      v = 8'($random(seed));
      pal[(i / 3) % 256][i % 3] = v;
      wr(`REG_PAL_DATA, v);
    end
    readpal(254, 4);
    widthSelect <= 1'b0;
    wide = 0;
    readpal(254, 2);
    $display("test palette width done");
    widthSelect <= 1'b1;
    wr(`REG_PAL_WADDR, `IDX_MISC_CTRL);
    wr(`REG_INDEXED, 8'h04);
    readpal(5, 1);
    wr(`REG_INDEXED, 8'h0C);
    wide = 1;
    readpal(6, 1);
    wr(`REG_INDEXED, 8'h00);
    $display("test override done");
    wr(`REG_COL_WADDR, 8'h07);
    for (int i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      col[(3 + i / 3) % 4][i % 3] = v;
      wr(`REG_COL_DATA, v);
    end
    wr(`REG_COL_RADDR, 8'h01);
    for (int i = 0; i < 12; i++) begin
      palette_host_i.get(`REG_COL_DATA, v);
      check("color", v, col[(1 + i / 3) % 4][i % 3]);
    end
    $display("test color registers done");
    for (int k = 0; k < 16; k++) begin
      wide = k < 8;
      widthSelect <= wide[0];
      mask = 8'($random(seed));
      page = 8'($random(seed));
      px = 8'($random(seed));
      wr(`REG_READ_MASK, mask);
      wr(`REG_PAL_WADDR, `IDX_PALETTE_PAGE);
      wr(`REG_INDEXED, page);
      @(posedge clk);
      pixelIn <= px;
      directColor <= k[2];
      pixelPlanes <= planes_type'(k % 4);
      repeat (4) @(posedge clk);
      m = (1 << (8 >> (k % 4))) - 1;
      a = ((k[2] ? px : px & mask) & m) | (page & ~m);
      want = {sh(pal[a][0]), sh(pal[a][1]), sh(pal[a][2])};
      check("dac", dacColor, want);
      // one checksum step, polynomial 0x07, over the shifted mux output
      c = crcRemainder;
      @(posedge clk);
      c = {c[6:0], 1'b0} ^ want.red ^ want.green ^ want.blue ^ (c[7] ? 8'h07 : 8'h00);
      check("crc", crcRemainder, c);
      wr(`REG_PAL_WADDR, `IDX_TEST_DATA);
      palette_host_i.get(`REG_INDEXED, v);
      check("test data", v, want.red);
    end
    ce <= 1'b0;
    pixelIn <= ~px;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    $display("test pixel path done");
    complete_run;
  end
endmodule // palette_color_access_bench
